// file: include/sxa_pkg.sv
// Purpose: Shared constants and types for the subtract/xor/swap ALU slice
// Assumes: AXI4-Lite register access with 32-bit data, byte addresses
// Notes:   All offsets, fields, opcodes and reset values live here

package sxa_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam int SXA_AW = 8;                       // Register address width
   localparam logic [7:0] REG_ACC    = 8'h00;       // Accumulator
   localparam logic [7:0] REG_STATUS = 8'h04;       // Carry, half borrow, zero
   localparam logic [7:0] REG_CMD    = 8'h08;       // Execute command
   localparam logic [7:0] REG_FADDR  = 8'h0C;       // File window address
   localparam logic [7:0] REG_FDATA  = 8'h10;       // File window data
   localparam logic [7:0] REG_DIR_A  = 8'h14;       // Port A direction
   localparam logic [7:0] REG_DIR_B  = 8'h18;       // Port B direction
   localparam logic [7:0] REG_DIR_C  = 8'h1C;       // Port C direction

   // ****************************************
   // Field positions
   // ****************************************
   localparam int ST_CARRY = 0;                     // Status carry bit
   localparam int ST_HALF  = 1;                     // Status half borrow bit
   localparam int ST_ZERO  = 2;                     // Status zero bit
   localparam int CMD_OP_LSB  = 0;                  // Opcode, 3 bits
   localparam int CMD_DEST    = 3;                  // Destination selector
   localparam int CMD_OPR_LSB = 8;                  // Operand, 8 bits
   localparam int FILE_AW     = 7;                  // File address width

   // ****************************************
   // Opcodes and operand values
   // ****************************************
   localparam logic [2:0] OP_LIT_SUB   = 3'h0;      // Literal minus acc
   localparam logic [2:0] OP_REG_SUB   = 3'h1;      // Register minus acc
   localparam logic [2:0] OP_REG_SUB_B = 3'h2;      // Same, with borrow
   localparam logic [2:0] OP_LIT_XOR   = 3'h3;      // Literal xor acc
   localparam logic [2:0] OP_REG_XOR   = 3'h4;      // Register xor acc
   localparam logic [2:0] OP_NIB_SWAP  = 3'h5;      // Nibble exchange
   localparam logic [2:0] OP_DIR_LOAD  = 3'h6;      // Direction load
   localparam logic [7:0] DIR_SEL_A = 8'h05;        // Selects port A
   localparam logic [7:0] DIR_SEL_B = 8'h06;        // Selects port B
   localparam logic [7:0] DIR_SEL_C = 8'h07;        // Selects port C
   localparam logic [7:0] DIR_RESET = 8'hFF;        // All pins input
   localparam logic [7:0] ZERO_BYTE = 8'h00;        // Zero result
   localparam logic [1:0] RESP_OKAY   = 2'h0;       // AXI OKAY
   localparam logic [1:0] RESP_SLVERR = 2'h2;       // AXI SLVERR

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic [2:0] op;                               // Opcode
      logic       dest;                             // 0 acc, 1 file
      logic [7:0] opr;                              // Literal or address
   } sxa_cmd_t;

   typedef struct packed {
      logic [7:0] res;                              // Result byte
      logic       carry;                            // New carry
      logic       half;                             // New half borrow
      logic       zero;                             // New zero
      logic       wr_arith;                         // Update carry and half
      logic       wr_zero;                          // Update zero
   } sxa_alu_t;

   typedef struct packed {
      logic              aw_have;                   // Write address held
      logic [SXA_AW-1:0] aw_addr;
      logic              w_have;                    // Write data held
      logic [31:0]       w_data;
      logic [3:0]        w_strb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
      logic [7:0]        acc;                       // Accumulator
      logic              carry;
      logic              half;
      logic              zero;
      logic [7:0]        dir_a;
      logic [7:0]        dir_b;
      logic [7:0]        dir_c;
      logic [FILE_AW-1:0] faddr;                    // File window pointer
   } sxa_state_t;

   localparam sxa_state_t STATE_RST = '{dir_a: DIR_RESET, dir_b: DIR_RESET,
      dir_c: DIR_RESET, default: '0};

endpackage : sxa_pkg

// file: design/sxa_alu.sv
// Purpose: Combinational result and flag logic for one operation
// Assumes: Operands already fetched by the caller
// Notes:   Subtraction is add of the inverted accumulator plus carry in

`timescale 1ns/10ps

module sxa_alu
   import sxa_pkg::*;
(
   // Operation
   input wire logic [2:0] op,
   input wire logic [7:0] opr,
   // Operands
   input wire logic [7:0] acc,
   input wire logic [7:0] fval,
   input wire logic carry_in,
   // Result
   output sxa_alu_t out
);

   logic [7:0] a_src;                               // Minuend or xor source
   logic       cin;                                 // Inverse of borrow
   logic [8:0] sum;                                 // Full width difference
   logic [4:0] low;                                 // Low nibble difference

   // ****************************************
   // Arithmetic and logic
   // ****************************************
   // Result and flags for each opcode
   always_comb begin
      a_src = (op == OP_LIT_SUB || op == OP_LIT_XOR) ? opr : fval;
      cin = (op == OP_REG_SUB_B) ? carry_in : 1'b1;
      sum = {1'b0, a_src} + {1'b0, ~acc} + {8'h00, cin};
      low = {1'b0, a_src[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, cin};
      out = '0;
      case (op)
         // Carry set when no borrow out
         OP_LIT_SUB, OP_REG_SUB, OP_REG_SUB_B: begin
            out.res = sum[7:0];
            out.carry = sum[8];
            out.half = low[4];
            out.wr_arith = 1'b1;
            out.wr_zero = 1'b1;
         end
         // Only zero changes
         OP_LIT_XOR, OP_REG_XOR: begin
            out.res = acc ^ a_src;
            out.wr_zero = 1'b1;
         end
         // Low nibble up, high nibble down
         OP_NIB_SWAP: begin
            out.res = {fval[3:0], fval[7:4]};
         end
         default: begin
            out.res = acc;
         end
      endcase
      out.zero = (out.res == ZERO_BYTE);
   end

endmodule : sxa_alu

// file: design/sxa_exec_top.sv
// Purpose: ALU execute slice with file registers and direction registers
// Assumes: AXI4-Lite master issues at most one write and one read at once
// Notes:   A write to the command register executes in one cycle
// How it works
// RULE_01: Literal minus accumulator, result into accumulator
// RULE_02: Literal subtract sets carry, half borrow, zero
// RULE_03: Register minus accumulator with carry, half borrow
// RULE_04: Selector 0 writes accumulator, 1 writes register
// RULE_05: Direction load copies accumulator to port 5-7
// RULE_06: Register minus accumulator minus inverted carry
// RULE_07: Borrow subtract updates flags, honours destination
// RULE_08: Literal xor into accumulator, zero only
// RULE_09: Nibble swap, no flags changed
// RULE_10: Register xor to destination, zero only
// RULE_11: Plain register subtract honours destination
// RULE_12: Zero flag set exactly when result zero
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.

`timescale 1ns/10ps

module sxa_exec_top
   import sxa_pkg::*;
#(
   parameter int FILE_DEPTH = 128                   // File registers fitted
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address channel
   input wire logic [SXA_AW-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   // Write data channel
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // Write response channel
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // Read address channel
   input wire logic [SXA_AW-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   // Read data channel
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Port direction outputs
   output logic [7:0] port_a_direction,
   output logic [7:0] port_b_direction,
   output logic [7:0] port_c_direction
);

   // ****************************************
   // Parameter check
   // ****************************************
   if (FILE_DEPTH < 1 || FILE_DEPTH > 128) begin : g_bad_depth
      $error("FILE_DEPTH must lie between 1 and 128");
   end

   // ****************************************
   // Declarations
   // ****************************************
   sxa_state_t s_r;                                 // All control state
   sxa_state_t s_nxt;                               // Next control state
   logic [7:0] file_mem [FILE_DEPTH];               // File registers
   logic mem_we;                                    // File write strobe
   logic [FILE_AW-1:0] mem_wa;                      // File write address
   logic [7:0] mem_wd;                              // File write data
   logic aw_fire;                                   // Address taken
   logic w_fire;                                    // Data taken
   logic ar_fire;                                   // Read taken
   logic wr_go;                                     // Both halves held
   logic exec;                                      // Command executes
   sxa_cmd_t cmd;                                   // Decoded command
   logic [FILE_AW-1:0] f_addr;                      // Operand address
   logic [7:0] f_val;                               // Operand register
   logic [7:0] win_val;                             // Window register
   logic file_op;                                   // Uses the selector
   sxa_alu_t alu;                                   // ALU answer
   localparam int unused_w = 6;
   logic [unused_w-1:0] unused_prot;                // Protection ignored

   assign unused_prot = {awprot, arprot};

   // ****************************************
   // Handshakes and outputs
   // ****************************************
   assign awready = !s_r.aw_have && !s_r.bvalid;
   assign wready = !s_r.w_have && !s_r.bvalid;
   assign arready = !s_r.rvalid;
   assign aw_fire = awvalid && awready;
   assign w_fire = wvalid && wready;
   assign ar_fire = arvalid && arready;
   assign wr_go = s_r.aw_have && s_r.w_have;
   assign bvalid = s_r.bvalid;
   assign bresp = s_r.bresp;
   assign rvalid = s_r.rvalid;
   assign rresp = s_r.rresp;
   assign rdata = s_r.rdata;
   assign port_a_direction = s_r.dir_a;
   assign port_b_direction = s_r.dir_b;
   assign port_c_direction = s_r.dir_c;

   // ****************************************
   // Operand fetch
   // ****************************************
   assign cmd.op = s_r.w_data[CMD_OP_LSB +: 3];
   assign cmd.dest = s_r.w_data[CMD_DEST];
   assign cmd.opr = s_r.w_data[CMD_OPR_LSB +: 8];
   assign f_addr = cmd.opr[FILE_AW-1:0];            // Address 0 to 127
   assign f_val = (int'(f_addr) < FILE_DEPTH) ? file_mem[f_addr] : ZERO_BYTE;
   assign win_val = (int'(s_r.faddr) < FILE_DEPTH) ?
      file_mem[s_r.faddr] : ZERO_BYTE;
   assign file_op = (cmd.op == OP_REG_SUB) || (cmd.op == OP_REG_SUB_B) ||
      (cmd.op == OP_REG_XOR) || (cmd.op == OP_NIB_SWAP);
   assign exec = wr_go && (s_r.aw_addr == REG_CMD);

   // Result and flag computation
   sxa_alu u_alu (
      .op(cmd.op),
      .opr(cmd.opr),
      .acc(s_r.acc),
      .fval(f_val),
      .carry_in(s_r.carry),
      .out(alu)
   );

   // ****************************************
   // Next state
   // ****************************************
   // Bus channels, register writes and execution
   always_comb begin
      s_nxt = s_r;
      mem_we = 1'b0;
      mem_wa = '0;
      mem_wd = ZERO_BYTE;
      // Capture write halves in either order
      if (aw_fire) begin
         s_nxt.aw_have = 1'b1;
         s_nxt.aw_addr = awaddr;
      end
      if (w_fire) begin
         s_nxt.w_have = 1'b1;
         s_nxt.w_data = wdata;
         s_nxt.w_strb = wstrb;
      end
      if (s_r.bvalid && bready) begin
         s_nxt.bvalid = 1'b0;
      end
      // Perform the write once both halves are held
      if (wr_go) begin
         s_nxt.aw_have = 1'b0;
         s_nxt.w_have = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = RESP_OKAY;
         case (s_r.aw_addr)
            // Accumulator load
            REG_ACC: begin
               if (s_r.w_strb[0]) begin
                  s_nxt.acc = s_r.w_data[7:0];
               end
            end
            // Flags load
            REG_STATUS: begin
               if (s_r.w_strb[0]) begin
                  s_nxt.carry = s_r.w_data[ST_CARRY];
                  s_nxt.half = s_r.w_data[ST_HALF];
                  s_nxt.zero = s_r.w_data[ST_ZERO];
               end
            end
            // Execute, strobes ignored
            REG_CMD: begin
               if (alu.wr_arith) begin
                  s_nxt.carry = alu.carry;    // RULE_02 RULE_03 RULE_07
                  s_nxt.half = alu.half;      // RULE_02 RULE_03 RULE_07
               end
               if (alu.wr_zero) begin
                  s_nxt.zero = alu.zero;      // RULE_12 RULE_08 RULE_10
               end
               case (cmd.op)
                  // Literal forms always land in the accumulator
                  OP_LIT_SUB, OP_LIT_XOR: begin
                     s_nxt.acc = alu.res;     // RULE_01 RULE_08
                  end
                  // Copy accumulator to selected direction register
                  OP_DIR_LOAD: begin
                     case (cmd.opr)
                        DIR_SEL_A: s_nxt.dir_a = s_r.acc;   // RULE_05
                        DIR_SEL_B: s_nxt.dir_b = s_r.acc;   // RULE_05
                        DIR_SEL_C: s_nxt.dir_c = s_r.acc;   // RULE_05
                        default: s_nxt.dir_a = s_r.dir_a;
                     endcase
                  end
                  default: begin
                     // Register forms follow the selector
                     if (file_op && cmd.dest) begin
                        mem_we = int'(f_addr) < FILE_DEPTH; // RULE_04
                        mem_wa = f_addr;
                        mem_wd = alu.res;     // RULE_11 RULE_09
                     end else if (file_op) begin
                        s_nxt.acc = alu.res;  // RULE_04 RULE_06 RULE_10
                     end
                  end
               endcase
            end
            // File window pointer
            REG_FADDR: begin
               if (s_r.w_strb[0]) begin
                  s_nxt.faddr = s_r.w_data[FILE_AW-1:0];
               end
            end
            // File window data
            REG_FDATA: begin
               if (s_r.w_strb[0]) begin
                  mem_we = int'(s_r.faddr) < FILE_DEPTH;
                  mem_wa = s_r.faddr;
                  mem_wd = s_r.w_data[7:0];
               end
            end
            // Read-only registers ignore writes
            REG_DIR_A, REG_DIR_B, REG_DIR_C: begin
               s_nxt.bresp = RESP_OKAY;
            end
            default: begin
               s_nxt.bresp = RESP_SLVERR;
            end
         endcase
      end
      // Read channel
      if (s_r.rvalid && rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (ar_fire) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = RESP_OKAY;
         s_nxt.rdata = '0;
         case (araddr)
            REG_ACC: s_nxt.rdata[7:0] = s_r.acc;
            REG_STATUS: begin
               s_nxt.rdata[ST_CARRY] = s_r.carry;
               s_nxt.rdata[ST_HALF] = s_r.half;
               s_nxt.rdata[ST_ZERO] = s_r.zero;
            end
            REG_CMD: s_nxt.rdata = '0;
            REG_FADDR: s_nxt.rdata[FILE_AW-1:0] = s_r.faddr;
            REG_FDATA: s_nxt.rdata[7:0] = win_val;
            REG_DIR_A: s_nxt.rdata[7:0] = s_r.dir_a;
            REG_DIR_B: s_nxt.rdata[7:0] = s_r.dir_b;
            REG_DIR_C: s_nxt.rdata[7:0] = s_r.dir_c;
            default: s_nxt.rresp = RESP_SLVERR;
         endcase
      end
   end

   // ****************************************
   // State registers
   // ****************************************
   // Control state with synchronous reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // File registers, not reset
   always_ff @(posedge aclk) begin
      if (mem_we) begin
         file_mem[mem_wa] <= mem_wd;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic [7:0] dif_lit;                             // Literal minus acc
   logic [7:0] dif_reg;                             // Register minus acc
   logic [7:0] dif_brw;                             // With borrow
   logic [8:0] need_brw;                            // Acc plus borrow
   logic [4:0] need_half;                           // Low nibble plus borrow
   assign dif_lit = cmd.opr - s_r.acc;
   assign dif_reg = f_val - s_r.acc;
   assign dif_brw = f_val - s_r.acc - {7'h00, !s_r.carry};
   assign need_brw = {1'b0, s_r.acc} + {8'h00, !s_r.carry};
   assign need_half = {1'b0, s_r.acc[3:0]} + {4'h0, !s_r.carry};

   // Expectations worked from operands, except dest_acc_a and zero_flag_a, which use the ALU answer
   lit_sub_result_a: assert property (exec && cmd.op == OP_LIT_SUB // RULE_01
      |=> s_r.acc == $past(dif_lit)) else $error("literal subtract wrong");
   lit_sub_flags_a: assert property (exec && cmd.op == OP_LIT_SUB // RULE_02
      |=> s_r.carry == $past(s_r.acc <= cmd.opr) &&
      s_r.half == $past(s_r.acc[3:0] <= cmd.opr[3:0]))
      else $error("literal subtract flags wrong");
   reg_sub_flags_a: assert property (exec && cmd.op == OP_REG_SUB // RULE_03
      |=> s_r.carry == $past(s_r.acc <= f_val) &&
      s_r.half == $past(s_r.acc[3:0] <= f_val[3:0]))
      else $error("register subtract flags wrong");
   dest_acc_a: assert property (exec && file_op && !cmd.dest // RULE_04
      && int'(f_addr) < FILE_DEPTH |=> s_r.acc == $past(alu.res) &&
      file_mem[$past(f_addr)] == $past(f_val))
      else $error("acc destination wrong");
   dir_load_a: assert property (exec && cmd.op == OP_DIR_LOAD && // RULE_05
      cmd.opr == DIR_SEL_B |=> s_r.dir_b == $past(s_r.acc) &&
      $stable(s_r.dir_a) && $stable({s_r.carry, s_r.half, s_r.zero}))
      else $error("direction load wrong");
   dir_other_a: assert property (exec && cmd.op == OP_DIR_LOAD && // RULE_05
      cmd.opr != DIR_SEL_A && cmd.opr != DIR_SEL_B && cmd.opr != DIR_SEL_C
      |=> $stable({s_r.dir_a, s_r.dir_b, s_r.dir_c, s_r.acc}))
      else $error("direction load with bad select");
   borrow_result_a: assert property (exec && cmd.op == OP_REG_SUB_B // RULE_06
      && !cmd.dest |=> s_r.acc == $past(dif_brw))
      else $error("borrow subtract wrong");
   borrow_flags_a: assert property (exec && cmd.op == OP_REG_SUB_B // RULE_07
      |=> s_r.carry == $past({1'b0, f_val} >= need_brw) &&
      s_r.half == $past({1'b0, f_val[3:0]} >= need_half))
      else $error("borrow flags wrong");
   lit_xor_a: assert property (exec && cmd.op == OP_LIT_XOR // RULE_08
      |=> s_r.acc == $past(s_r.acc ^ cmd.opr) && $stable(s_r.carry) &&
      $stable(s_r.half)) else $error("literal xor wrong");
   swap_file_a: assert property (exec && cmd.op == OP_NIB_SWAP && // RULE_09
      cmd.dest && int'(f_addr) < FILE_DEPTH |=> file_mem[$past(f_addr)]
      == $past({f_val[3:0], f_val[7:4]}) &&
      $stable({s_r.acc, s_r.carry, s_r.half, s_r.zero}))
      else $error("swap to file wrong");
   swap_acc_a: assert property (exec && cmd.op == OP_NIB_SWAP && // RULE_09
      !cmd.dest |=> s_r.acc == $past({f_val[3:0], f_val[7:4]}) &&
      $stable({s_r.carry, s_r.half, s_r.zero}))
      else $error("swap to accumulator wrong");
   reg_xor_a: assert property (exec && cmd.op == OP_REG_XOR // RULE_10
      |=> $stable(s_r.carry) && $stable(s_r.half) &&
      s_r.zero == $past((s_r.acc ^ f_val) == ZERO_BYTE))
      else $error("register xor flags wrong");
   sub_to_file_a: assert property (exec && cmd.op == OP_REG_SUB && // RULE_11
      cmd.dest && int'(f_addr) < FILE_DEPTH |=> file_mem[$past(f_addr)] ==
      $past(dif_reg) && $stable(s_r.acc))
      else $error("subtract to file wrong");
   zero_flag_a: assert property (exec && alu.wr_zero // RULE_12
      |=> s_r.zero == ($past(alu.res) == ZERO_BYTE))
      else $error("zero flag wrong");

endmodule : sxa_exec_top

// file: test/tb.sv
// Purpose: Self-checking bench for the ALU execute slice
// Assumes: Slave answers every bus request within fifty cycles
// Notes:   Table rows first, then direction, error and reset cases

`timescale 1ns/10ps

// Compare, count, report a mismatch
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   failures++; $display("BAD %s exp %h got %h", nm, e, g); end end

module tb
   import sxa_pkg::*;
;
   // ************************
   // Signals and table
   // ************************
   logic aclk = 1'h0;
   logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr, pa, pb, pc;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rr;
   logic [23:0] dv;                  // Expected directions, C B A
   int failures = 0;
   int cmp_count = 0;
   int i, s;
   // One row: inputs, then expected acc, status, file value
   typedef struct packed {
      logic [7:0] acc; logic [2:0] st; logic [7:0] fv; logic [2:0] op;
      logic d; logic [7:0] opr; logic [7:0] ea; logic [2:0] es;
      logic [7:0] ef;
   } sxa_row_t;
   sxa_row_t rows [14] = '{
      '{8'h05,3'h0,8'h33,OP_LIT_SUB,1'h0,8'h05,8'h00,3'h7,8'h33},
      '{8'h06,3'h0,8'h33,OP_LIT_SUB,1'h0,8'h05,8'hFF,3'h0,8'h33},
      '{8'h0F,3'h0,8'h33,OP_LIT_SUB,1'h0,8'h10,8'h01,3'h1,8'h33},
      '{8'h12,3'h0,8'h33,OP_REG_SUB,1'h0,8'h10,8'h21,3'h3,8'h33},
      '{8'h34,3'h7,8'h33,OP_REG_SUB,1'h1,8'h10,8'h34,3'h0,8'hFF},
      '{8'h33,3'h1,8'h33,OP_REG_SUB_B,1'h0,8'h10,8'h00,3'h7,8'h33},
      '{8'h32,3'h0,8'h33,OP_REG_SUB_B,1'h1,8'h10,8'h32,3'h7,8'h00},
      '{8'h33,3'h0,8'h33,OP_REG_SUB_B,1'h0,8'h10,8'hFF,3'h0,8'h33},
      '{8'hA5,3'h3,8'h33,OP_LIT_XOR,1'h0,8'hA5,8'h00,3'h7,8'h33},
      '{8'hA5,3'h4,8'h33,OP_LIT_XOR,1'h0,8'h0F,8'hAA,3'h0,8'h33},
      '{8'h0F,3'h7,8'h33,OP_REG_XOR,1'h1,8'h10,8'h0F,3'h3,8'h3C},
      '{8'h33,3'h0,8'h33,OP_REG_XOR,1'h0,8'h10,8'h00,3'h4,8'h33},
      '{8'h11,3'h5,8'h3A,OP_NIB_SWAP,1'h0,8'h10,8'hA3,3'h5,8'h3A},
      '{8'h11,3'h2,8'h3A,OP_NIB_SWAP,1'h1,8'h10,8'h11,3'h2,8'hA3}};

   // Clock at 100 ns period
   always #50 aclk = ~aclk;

   sxa_exec_top #(.FILE_DEPTH(128)) dut (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .port_a_direction(pa), .port_b_direction(pb),
      .port_c_direction(pc));

   // ************************
   // Bus tasks
   // ************************
   // Closing report and end of run
   task automatic test_done();
      $display("Compares %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done

   // Wait that ran out counts as a mismatch
   task automatic tmo(input int n);
      if (n >= 50) begin
         failures++;
         test_done();
      end
   endtask : tmo

   // Write: address and data offered together, each dropped when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er);
      int n;
      logic ad, wd;
      ad = 0;
      wd = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (n = 0; n < 50 && !(ad && wd); n++) begin
         @(negedge aclk);
         if (awvalid && awready === 1'h1) ad = 1;
         if (wvalid && wready === 1'h1) wd = 1;
         @(posedge aclk);
         if (ad) awvalid <= 1'h0;
         if (wd) wvalid <= 1'h0;
      end
      tmo(n);
      for (n = 0; n < 50; n++) begin
         @(negedge aclk);
         if (bvalid === 1'h1) break;
      end
      tmo(n);
      `CHK("bresp", er, bresp)
      @(posedge aclk);
      bready <= 1'h0;
      // Idle edge so a following call never re-raises bready in this step
      @(posedge aclk);
   endtask : axw

   // Read: address held until taken, data taken with rready high
   task automatic axr(input logic [7:0] a);
      int n;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(negedge aclk);
         if (arready === 1'h1) break;
      end
      tmo(n);
      @(posedge aclk);
      arvalid <= 1'h0;
      for (n = 0; n < 50; n++) begin
         @(negedge aclk);
         if (rvalid === 1'h1) break;
      end
      tmo(n);
      rd = rdata;
      rr = rresp;
      @(posedge aclk);
      rready <= 1'h0;
      // Idle edge so a following call never re-raises rready in this step
      @(posedge aclk);
   endtask : axr

   // Read one register and compare its word
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      axr(a);
      `CHK("rdata", {24'h0, e}, rd)
      `CHK("rresp", RESP_OKAY, rr)
   endtask : rchk

   function automatic logic [31:0] cw(logic [2:0] o, logic d, logic [7:0] p);
      return {16'h0, p, 4'h0, d, o};
   endfunction : cw

   // ************************
   // Main sequence
   // ************************
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, awprot, arprot, wdata} = '0;
      wstrb = 4'hF;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      axw(REG_FADDR, 32'h10, RESP_OKAY);
      // Table rows: load operands, execute, read back
      for (i = 0; i < 14; i++) begin
         axw(REG_ACC, {24'h0, rows[i].acc}, RESP_OKAY);
         axw(REG_STATUS, {29'h0, rows[i].st}, RESP_OKAY);
         axw(REG_FDATA, {24'h0, rows[i].fv}, RESP_OKAY);
         axw(REG_CMD, cw(rows[i].op, rows[i].d, rows[i].opr), RESP_OKAY);
         rchk(REG_ACC, rows[i].ea);
         rchk(REG_STATUS, {5'h0, rows[i].es});
         rchk(REG_FDATA, rows[i].ef);
      end
      // An invalid select first, then direction loads for each select
      dv = 24'hFFFFFF;
      axw(REG_STATUS, 32'h5, RESP_OKAY);
      for (s = 4; s < 8; s++) begin
         axw(REG_ACC, 32'h50 + s, RESP_OKAY);
         axw(REG_CMD, cw(OP_DIR_LOAD, 1'h0, 8'(s)), RESP_OKAY);
         if (s > 4) dv[(s - 5) * 8 +: 8] = 8'(8'h50 + s);
         `CHK("dirs", dv, {pc, pb, pa})
      end
      // Spare opcode leaves accumulator, flags and file alone
      axw(REG_CMD, cw(3'h7, 1'h1, 8'h10), RESP_OKAY);
      rchk(REG_ACC, 8'h57);
      rchk(REG_FDATA, 8'hA3);
      rchk(REG_STATUS, 8'h05);
      // Read-only and unmapped places
      axw(REG_DIR_A, 32'h0, RESP_OKAY);
      `CHK("dirs", dv, {pc, pb, pa})
      axw(8'h20, 32'h0, RESP_SLVERR);
      axr(8'h20);
      `CHK("rresp", RESP_SLVERR, rr)
      // Reset in mid-run restores defaults
      aresetn <= 1'h0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      `CHK("dirs", {3{DIR_RESET}}, {pc, pb, pa})
      rchk(REG_ACC, 8'h00);
      rchk(REG_STATUS, 8'h00);
      test_done();
   end
endmodule : tb
